// ==== common/ulb_pkg.sv ====
/*
 * shared constants and types for the lin break / wake serial extension.
 * assumes one system clock and an 8-bit register port with 3-bit address.
 */
package ulb_pkg;

	// register port
	localparam int          ADDR_W        = 3;
	localparam int          DATA_W        = 8;
	localparam logic [2:0]  ADDR_RX_STAT  = 3'h0;
	localparam logic [2:0]  ADDR_TX_STAT  = 3'h1;
	localparam logic [2:0]  ADDR_BAUD_CTL = 3'h2;
	localparam logic [2:0]  ADDR_TX_DATA  = 3'h3;
	localparam logic [2:0]  ADDR_RX_DATA  = 3'h4;
	localparam logic [2:0]  ADDR_BAUD_DIV = 3'h5;
	localparam logic [2:0]  ADDR_FLAGS    = 3'h6;

	// transmit_status_reg fields
	localparam int TXS_CLK_MASTER  = 7;
	localparam int TXS_TX_EN       = 5;
	localparam int TXS_SYNC        = 4;
	localparam int TXS_SEND_BRK    = 3;
	localparam int TXS_SHIFT_EMPTY = 1;
	// receive_status_reg fields
	localparam int RXS_PORT_EN     = 7;
	localparam int RXS_SINGLE_RX   = 5;
	localparam int RXS_CONT_RX     = 4;
	// baud_control_reg fields
	localparam int BC_RX_IDLE      = 6;
	localparam int BC_CLK_POL      = 4;
	localparam int BC_WAKE_EN      = 1;
	localparam int BC_AUTOBAUD     = 0;
	// flag register fields
	localparam int FL_RX_FLAG      = 5;
	localparam int FL_TX_EMPTY     = 4;

	// reset values
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] BAUD_DIV_RESET = 8'h0f;

	// timing and framing
	localparam logic [3:0] SAMPLE_LAST   = 4'hf;
	localparam logic [3:0] SAMPLE_MID    = 4'h7;
	localparam int         BRK_ZERO_BITS = 12;
	localparam int         FRAME_W       = BRK_ZERO_BITS + 2;
	localparam logic [3:0] BRK_FRAME_LEN = 4'he;
	localparam logic [3:0] ASYNC_LEN     = 4'ha;
	localparam logic [3:0] SYNC_LEN      = 4'h8;
	localparam logic [2:0] LAST_DATA_BIT = 3'h7;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ulb_bus_req_s;

	typedef struct packed {
		logic tx_out;
		logic tx_oe;
		logic rx_out;
		logic rx_oe;
	} ulb_pins_s;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} ulb_rx_state_e;

endpackage

// ==== design/ulb_wake_det.sv ====
/*
 * falling-edge wake detector on the receive pin, independent of any baud clock.
 * assumes i_arm is a flop output of the system clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module ulb_wake_det
(
	// system
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// control and pin
	input  wire logic i_arm,
	input  wire logic i_rx_pin,
	// results
	output logic      o_wake_async,
	output logic      o_wake_lvl,
	output logic      o_wake_pulse
);
	logic latch_q;
	logic meta_q;
	logic sync_q;
	logic prev_q;
	wire  clr_n = i_rst_n & i_arm;

	// the pin itself clocks the latch, so it works with all clocks stopped
	always_ff @(negedge i_rx_pin or negedge clr_n)
	begin
		if (!clr_n)
			latch_q <= 1'b0;
		else
			latch_q <= 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= latch_q;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign o_wake_async = latch_q;
	assign o_wake_lvl   = sync_q;
	assign o_wake_pulse = sync_q & ~prev_q;
endmodule
`default_nettype wire

// ==== design/ulb_tx_shift.sv ====
/*
 * transmit shift register: normal async character, 8-bit sync word or break.
 * assumes i_bit_tick pulses once per bit time and i_load only while idle.
 */
`timescale 1ns/10ps
`default_nettype none
module ulb_tx_shift
	import ulb_pkg::*;
(
	// system
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// control
	input  wire logic       i_bit_tick,
	input  wire logic       i_load,
	input  wire logic       i_break,
	input  wire logic       i_sync,
	input  wire logic [7:0] i_data,
	// status
	output logic            o_bit,
	output logic            o_busy,
	output logic            o_brk_done
);
	logic [FRAME_W-1:0] sh_q;
	logic [3:0]         cnt_q;
	logic               brk_q;
	logic               busy_q;
	logic               last_bit;
	logic [FRAME_W-1:0] load_frame;
	logic [3:0]         load_len;

	assign last_bit   = busy_q & i_bit_tick & (cnt_q == 4'h1);
	// break: start, twelve zeros, stop; written data ignored
	assign load_frame = i_break ? {1'b1, {(FRAME_W-1){1'b0}}} :
	                    i_sync  ? {{(FRAME_W-8){1'b1}}, i_data} :
	                              {{(FRAME_W-9){1'b1}}, i_data, 1'b0};
	assign load_len   = i_break ? BRK_FRAME_LEN : (i_sync ? SYNC_LEN : ASYNC_LEN);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sh_q   <= '1;
			cnt_q  <= 4'h0;
			brk_q  <= 1'b0;
			busy_q <= 1'b0;
		end
		else if (i_load && !busy_q)
		begin
			sh_q   <= load_frame;
			cnt_q  <= load_len;
			brk_q  <= i_break;
			busy_q <= 1'b1;
		end
		else if (busy_q && i_bit_tick)
		begin
			sh_q   <= {1'b1, sh_q[FRAME_W-1:1]};
			cnt_q  <= cnt_q - 4'h1;
			busy_q <= ~last_bit;
		end
	end

	assign o_bit      = busy_q ? sh_q[0] : 1'b1;
	assign o_busy     = busy_q;
	assign o_brk_done = last_bit & brk_q;

	chk_break_zeros_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(busy_q && brk_q && cnt_q > 4'h1) |-> (o_bit == 1'b0))
		else $error("break frame drove a high bit before its stop bit");
	chk_break_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_load && !busy_q && i_break) |=> (cnt_q == 4'he && brk_q))
		else $error("break frame did not load fourteen bit times");
endmodule
`default_nettype wire

// ==== design/ulb_top.sv ====
/*
 * lin break and wake extensions of a serial port: wake on receive edge,
 * break send, minimal 16x receiver, sync master pin assignment.
 * assumes i_sleep comes from the power controller on i_clk, and the
 * register master obeys single-cycle strobes, never both at once.
 */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - sleep stops baud ticks and byte reception
// - wake enable holds receiver idle
// - falling receive line is the wake event
// - wake event sets receive flag
// - reading receive data clears receive flag
// - next rising edge clears wake enable
// - break is start, twelve zeros, stop
// - send-break plus load sends zeros
// - send-break self clears after stop bit
// - shift empty flag tracks break too
// - wake sees two edges, then next byte
// - sync master is half duplex
// - sync port pins become clock and data
// - clock idles at selected polarity
// - buffer move sets transmit buffer empty
module ulb_top
	import ulb_pkg::*;
(
	// system
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_sleep,
	// register port
	input  wire ulb_pkg::ulb_bus_req_s i_bus,
	output logic [7:0]              o_rdata,
	// pins
	input  wire logic               i_tx_in,
	input  wire logic               i_rx_in,
	output ulb_pkg::ulb_pins_s      o_pins,
	// status
	output logic                    o_rx_flag,
	output logic                    o_tx_empty_flag,
	output logic                    o_wake_async
);
	// software registers
	logic [7:0]    rx_stat_q;
	logic [7:0]    tx_stat_q;
	logic [7:0]    baud_ctl_q;
	logic [7:0]    baud_div_q;
	logic [7:0]    tx_data_q;
	logic [7:0]    rx_data_q;
	logic [7:0]    rdata_q;
	logic          tx_full_q;
	logic          rx_flag_q;
	logic          tx_empty_q;
	// receive pin synchroniser and receiver
	logic          rx_meta_q;
	logic          rx_sync_q;
	logic          rx_prev_q;
	ulb_rx_state_e rx_state_q;
	logic [3:0]    rx_cnt_q;
	logic [2:0]    rx_bits_q;
	logic [7:0]    rx_sh_q;
	// baud and transmit
	logic [7:0]    div_cnt_q;
	logic [3:0]    tx_sub_q;
	ulb_pins_s     pins_q;

	logic wr_rx_stat;
	logic wr_tx_stat;
	logic wr_baud_ctl;
	logic wr_tx_data;
	logic rd_rx_data;
	logic wr_baud_div;
	logic wake_on_edge_enable;
	logic serial_port_enable;
	logic sync_mode;
	logic clk_master;
	logic tick16;
	logic bit_tick;
	logic rx_fall;
	logic rx_rise;
	logic rx_busy;
	logic rx_done;
	logic rx_go;
	logic tx_load;
	logic tx_busy;
	logic tx_bit;
	logic brk_done;
	logic wake_lvl;
	logic wake_pulse;
	logic wake_end;
	logic [7:0] rd_mux;

	function automatic logic hit(input ulb_bus_req_s b, input logic [2:0] a, input logic wr);
		hit = (b.addr == a) & (wr ? b.wr : b.rd);
	endfunction

	assign wr_rx_stat  = hit(i_bus, ADDR_RX_STAT, 1'b1);
	assign wr_tx_stat  = hit(i_bus, ADDR_TX_STAT, 1'b1);
	assign wr_baud_ctl = hit(i_bus, ADDR_BAUD_CTL, 1'b1);
	assign wr_tx_data  = hit(i_bus, ADDR_TX_DATA, 1'b1);
	assign wr_baud_div = hit(i_bus, ADDR_BAUD_DIV, 1'b1);
	assign rd_rx_data  = hit(i_bus, ADDR_RX_DATA, 1'b0);

	assign wake_on_edge_enable        = baud_ctl_q[BC_WAKE_EN];
	assign serial_port_enable       = rx_stat_q[RXS_PORT_EN];
	assign sync_mode  = tx_stat_q[TXS_SYNC];
	assign clk_master = tx_stat_q[TXS_CLK_MASTER];

	// baud ticks stand still in sleep; >= lets a smaller divisor act without a wrap
	assign tick16   = ~i_sleep & (div_cnt_q >= baud_div_q);
	assign bit_tick = tick16 & (tx_sub_q == SAMPLE_LAST);

	assign rx_fall  = rx_prev_q & ~rx_sync_q;
	assign rx_rise  = rx_sync_q & ~rx_prev_q;
	assign rx_busy  = (rx_state_q != RX_IDLE);
	// start only when awake, not waiting for wake, not in sync, not mid sync transmit
	assign rx_go    = rx_fall & ~wake_on_edge_enable & ~i_sleep & serial_port_enable & ~sync_mode
	                  & rx_stat_q[RXS_CONT_RX] & ~(sync_mode & tx_busy);
	assign rx_done  = (rx_state_q == RX_STOP) & tick16 & (rx_cnt_q == SAMPLE_LAST);

	// a rising edge after the wake event ends the break
	assign wake_end = wake_on_edge_enable & wake_lvl & rx_rise;

	// transmit buffer moves only while the shift register is idle
	assign tx_load  = tx_full_q & tx_stat_q[TXS_TX_EN] & serial_port_enable & ~tx_busy
	                  & ~(sync_mode & rx_busy);

	ulb_wake_det u_wake
	(
		.i_clk        (i_clk),
		.i_rst_n      (i_rst_n),
		.i_arm        (wake_on_edge_enable),
		.i_rx_pin     (i_rx_in),
		.o_wake_async (o_wake_async),
		.o_wake_lvl   (wake_lvl),
		.o_wake_pulse (wake_pulse)
	);

	ulb_tx_shift u_tx
	(
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_bit_tick (bit_tick),
		.i_load     (tx_load),
		.i_break    (tx_stat_q[TXS_SEND_BRK] & ~sync_mode),
		.i_sync     (sync_mode),
		.i_data     (tx_data_q),
		.o_bit      (tx_bit),
		.o_busy     (tx_busy),
		.o_brk_done (brk_done)
	);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_meta_q <= 1'b1;
			rx_sync_q <= 1'b1;
			rx_prev_q <= 1'b1;
			div_cnt_q <= 8'h00;
			tx_sub_q  <= 4'h0;
		end
		else
		begin
			rx_meta_q <= i_rx_in;
			rx_sync_q <= rx_meta_q;
			rx_prev_q <= rx_sync_q;
			if (!i_sleep)
				div_cnt_q <= tick16 ? 8'h00 : div_cnt_q + 8'h01;
			if (tx_load)
				tx_sub_q <= 4'h0;
			else if (tick16)
				tx_sub_q <= tx_sub_q + 4'h1;
		end
	end

	// software registers; a software write beats a same-cycle hardware clear
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_stat_q  <= REG_RESET;
			tx_stat_q  <= REG_RESET;
			baud_ctl_q <= REG_RESET;
			baud_div_q <= BAUD_DIV_RESET;
			tx_data_q  <= REG_RESET;
		end
		else
		begin
			if (wr_rx_stat)
				rx_stat_q <= i_bus.wdata;
			if (wr_tx_stat)
				tx_stat_q <= i_bus.wdata;
			else if (brk_done)
				tx_stat_q[TXS_SEND_BRK] <= 1'b0;
			if (wr_baud_ctl)
				baud_ctl_q <= i_bus.wdata;
			else if (wake_end)
				baud_ctl_q[BC_WAKE_EN] <= 1'b0;
			if (wr_baud_div)
				baud_div_q <= i_bus.wdata;
			if (wr_tx_data)
				tx_data_q <= i_bus.wdata;
		end
	end

	// flags: a set wins over a clear, but a data write leaves the buffer full
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_full_q  <= 1'b0;
			tx_empty_q <= 1'b0;
			rx_flag_q  <= 1'b0;
		end
		else
		begin
			if (wr_tx_data)
				tx_full_q <= 1'b1;
			else if (tx_load)
				tx_full_q <= 1'b0;
			if (wr_tx_data)
				tx_empty_q <= 1'b0;
			else if (tx_load || (wr_tx_stat && i_bus.wdata[TXS_TX_EN] && !tx_full_q))
				tx_empty_q <= 1'b1;
			if ((wake_pulse && wake_on_edge_enable) || rx_done)
				rx_flag_q <= 1'b1;
			else if (rd_rx_data)
				rx_flag_q <= 1'b0;
		end
	end

	// minimal 16x receiver for the byte that follows a wake or break
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_state_q <= RX_IDLE;
			rx_cnt_q   <= 4'h0;
			rx_bits_q  <= 3'h0;
			rx_sh_q    <= 8'h00;
			rx_data_q  <= 8'h00;
		end
		else
		begin
			if (tick16)
				rx_cnt_q <= rx_cnt_q + 4'h1;
			case (rx_state_q)
				RX_IDLE:
				begin
					rx_cnt_q <= 4'h0;
					if (rx_go)
						rx_state_q <= RX_START;
				end
				RX_START:
					if (tick16 && rx_cnt_q == SAMPLE_MID)
					begin
						rx_cnt_q   <= 4'h0;
						rx_bits_q  <= 3'h0;
						rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
					end
				RX_DATA:
					if (tick16 && rx_cnt_q == SAMPLE_LAST)
					begin
						rx_sh_q   <= {rx_sync_q, rx_sh_q[7:1]};
						rx_bits_q <= rx_bits_q + 3'h1;
						if (rx_bits_q == LAST_DATA_BIT)
							rx_state_q <= RX_STOP;
					end
				RX_STOP:
					if (rx_done)
					begin
						rx_data_q  <= rx_sh_q;
						rx_state_q <= RX_IDLE;
					end
				default:
					rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// read back; status bits come straight from live state
	always_comb
	begin
		rd_mux = 8'h00;
		case (i_bus.addr)
			ADDR_RX_STAT:  rd_mux = rx_stat_q;
			ADDR_TX_STAT:
			begin
				rd_mux = tx_stat_q;
				rd_mux[TXS_SHIFT_EMPTY] = ~tx_busy;
			end
			ADDR_BAUD_CTL:
			begin
				rd_mux = baud_ctl_q;
				rd_mux[BC_RX_IDLE] = ~rx_busy;
			end
			ADDR_TX_DATA:  rd_mux = tx_data_q;
			ADDR_RX_DATA:  rd_mux = rx_data_q;
			ADDR_BAUD_DIV: rd_mux = baud_div_q;
			ADDR_FLAGS:
			begin
				rd_mux[FL_RX_FLAG]  = rx_flag_q;
				rd_mux[FL_TX_EMPTY] = tx_empty_q;
			end
			default:       rd_mux = 8'h00;
		endcase
	end

	// pins: sync master turns tx into shift clock and rx into data
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pins_q  <= '{tx_out: 1'b1, tx_oe: 1'b0, rx_out: 1'b1, rx_oe: 1'b0};
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= i_bus.rd ? rd_mux : 8'h00;
			if (sync_mode)
			begin
				pins_q.tx_out <= baud_ctl_q[BC_CLK_POL] ^ (tx_busy & tx_sub_q[3]);
				pins_q.tx_oe  <= serial_port_enable & clk_master;
				pins_q.rx_out <= tx_bit;
				pins_q.rx_oe  <= serial_port_enable & tx_busy;
			end
			else
			begin
				pins_q.tx_out <= tx_bit;
				pins_q.tx_oe  <= serial_port_enable;
				pins_q.rx_out <= 1'b1;
				pins_q.rx_oe  <= 1'b0;
			end
		end
	end

	assign o_rdata         = rdata_q;
	assign o_pins          = pins_q;
	assign o_rx_flag       = rx_flag_q;
	assign o_tx_empty_flag = tx_empty_q;

	chk_wake_sets_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wake_pulse && wake_on_edge_enable) |=> rx_flag_q)
		else $error("wake event did not raise the receive flag");
	chk_read_clears_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(rd_rx_data && !rx_done && !(wake_pulse && wake_on_edge_enable)) |=> !rx_flag_q)
		else $error("receive data read left the receive flag set");
	chk_wake_auto_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wake_end && !wr_baud_ctl) |=> !wake_on_edge_enable ##2 !wake_lvl)
		else $error("wake enable not cleared after the rising edge");
	chk_wake_holds_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wake_on_edge_enable && rx_state_q == RX_IDLE) |=> (rx_state_q == RX_IDLE))
		else $error("receiver left idle while wake enable was set");
	chk_sleep_no_rx: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_sleep && !rx_busy) |=> (!rx_busy && $stable(rx_data_q)))
		else $error("byte reception progressed during sleep");
	chk_send_break_request_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(brk_done && !wr_tx_stat) |=> !tx_stat_q[TXS_SEND_BRK])
		else $error("send-break request survived its stop bit");
	chk_shift_empty_read: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		hit(i_bus, ADDR_TX_STAT, 1'b0) |=> (o_rdata[TXS_SHIFT_EMPTY] == !$past(tx_busy)))
		else $error("shift empty flag disagrees with the shifter");
	chk_buffer_move: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(tx_load && !wr_tx_data) |=> (tx_empty_q && !tx_full_q && tx_busy))
		else $error("buffer move did not set the empty flag");
	chk_half_duplex: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(sync_mode && tx_busy) |-> !rx_go)
		else $error("reception started during a sync transmit");
	chk_clock_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(sync_mode && !tx_busy && $stable(baud_ctl_q)) |=>
		(o_pins.tx_out == $past(baud_ctl_q[BC_CLK_POL])))
		else $error("shift clock not at its idle level");

	cov_wake_then_end: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		(wake_pulse && wake_on_edge_enable) ##[1:1000] wake_end);
	cov_break_sent: cover property (@(posedge i_clk) disable iff (!i_rst_n) brk_done);
	cov_byte_after_wake: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		wake_end ##[1:1000] rx_done);
	cov_sync_tx: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		sync_mode && tx_busy && o_pins.rx_oe);
endmodule
`default_nettype wire

// ==== dv/ulb_remote_node.sv ====
/*
 * remote serial node model: drives the receive line with wake characters and bytes.
 * assumes calls start just after a rising edge of i_clk; the line idles high (pull-up).
 */
`timescale 1ns/10ps
`default_nettype none
module ulb_remote_node
#(
	parameter int BIT_CLKS = 16
)
(
	// system
	input  wire logic i_clk,
	// line
	output var logic  o_line
);
	initial o_line = 1'b1;

	task automatic hold(input logic v, input int bits);
		o_line <= v;
		repeat (bits * BIT_CLKS) @(posedge i_clk);
	endtask

	// no rising edge inside the character, or the wake state ends early
	task automatic send_zeros(input int bits);
		hold(1'b0, bits);
		hold(1'b1, 2);
	endtask

	task automatic send_byte(input logic [7:0] b);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++)
			hold(b[i], 1);
		hold(1'b1, 2);
	endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
/*
 * self-checking bench for ulb_top: registers, break send, wake while asleep, sync pins.
 * assumes ulb_remote_node on the receive line and a 250 MHz clock; divisor 0 gives 16 clocks a bit.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ulb_pkg::*;

	typedef struct packed {
		logic [7:0] exp;
		logic [7:0] mask;
	} ulb_note_s;

	localparam logic [9:0] FRAME_55 = {1'b1, 8'h55, 1'b0};

	logic         i_clk;
	logic         i_rst_n;
	logic         sleep;
	ulb_bus_req_s bus;
	logic [7:0]   rdata;
	ulb_pins_s    pins;
	logic         rx_flag;
	logic         tx_empty;
	logic         wake_async;
	logic         node_line;
	wire logic    rx_line;
	logic         rd_d;
	ulb_note_s    notes[$];
	ulb_note_s    nt;
	int           failures;
	int           checks;
	logic [7:0]   rnd;
	time          t0;

	// the design drives the data line only in sync transmit
	assign rx_line = pins.rx_oe ? pins.rx_out : node_line;

	ulb_top uut (
		.i_clk          (i_clk),
		.i_rst_n        (i_rst_n),
		.i_sleep        (sleep),
		.i_bus          (bus),
		.o_rdata        (rdata),
		.i_tx_in        (1'b1),
		.i_rx_in        (rx_line),
		.o_pins         (pins),
		.o_rx_flag      (rx_flag),
		.o_tx_empty_flag(tx_empty),
		.o_wake_async   (wake_async)
	);

	ulb_remote_node #(.BIT_CLKS(16)) node (.i_clk(i_clk), .o_line(node_line));

	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		notes.push_back('{exp: e, mask: m});
		@(posedge i_clk);
	endtask

	// strobes drop here, so a following request never shares this time step
	task automatic idle(input int cyc);
		bus <= '0;
		repeat (cyc) @(posedge i_clk);
	endtask

	function automatic logic probe(input int sel);
		case (sel)
			0: probe = pins.tx_out;
			1: probe = wake_async;
			default: probe = rx_flag;
		endcase
	endfunction

	task automatic wait_for(input int sel, input logic v, input int lim);
		int n;
		n = 0;
		while (probe(sel) !== v && n < lim)
		begin
			@(posedge i_clk);
			n++;
		end
		if (probe(sel) !== v)
		begin
			check(16'(probe(sel)), 16'(v));
			stop_test();
		end
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge i_clk)
	begin
		rd_d <= bus.rd;
		if (rd_d === 1'b1)
		begin
			nt = notes.pop_front();
			check(16'(rdata & nt.mask), 16'(nt.exp & nt.mask));
		end
	end

	initial
	begin
		failures = 0;
		checks = 0;
		sleep = 1'b0;
		bus = '0;
		i_rst_n = 1'b0;
		void'($urandom(32'h2645));
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rd(ADDR_BAUD_DIV, BAUD_DIV_RESET, 8'hff);
		rd(3'h7, 8'h00, 8'hff);
		wr(3'h7, 8'hff);
		wr(ADDR_FLAGS, 8'hff);
		rd(ADDR_FLAGS, 8'h00, 8'hff);
		rd(3'h7, 8'h00, 8'hff);
		wr(ADDR_BAUD_DIV, 8'h00);
		wr(ADDR_RX_STAT, 8'h80);
		wr(ADDR_TX_STAT, 8'h28);
		wr(ADDR_TX_DATA, 8'hff);
		wr(ADDR_TX_DATA, 8'h55);
		idle(1);
		wait_for(0, 1'b0, 20);
		t0 = $time;
		check(16'(tx_empty), 16'h0000);
		rd(ADDR_TX_STAT, 8'h28, 8'hff);
		rd(ADDR_FLAGS, 8'h00, 8'h30);
		idle(1);
		wait_for(0, 1'b1, 400);
		check(16'(($time - t0) / 4), 16'((BRK_ZERO_BITS + 1) * 16));
		wait_for(0, 1'b0, 40);
		repeat (8) @(posedge i_clk);
		for (int i = 0; i < 10; i++)
		begin
			check(16'(probe(0)), 16'(FRAME_55[i]));
			repeat (16) @(posedge i_clk);
		end
		check(16'(tx_empty), 16'h0001);
		rd(ADDR_TX_STAT, 8'h22, 8'hff);
		rd(ADDR_FLAGS, 8'h10, 8'h30);
		wr(ADDR_BAUD_CTL, 8'h01);
		idle(1);
		sleep <= 1'b1;
		wr(ADDR_RX_STAT, 8'h90);
		idle(1);
		rnd = 8'($urandom);
		node.send_byte(rnd);
		rd(ADDR_FLAGS, 8'h00, 8'h20);
		rd(ADDR_BAUD_CTL, 8'h41, 8'hff);
		wr(ADDR_BAUD_CTL, 8'h02);
		idle(4);
		fork
			node.send_zeros(13);
			begin
				wait_for(1, 1'b1, 4);
				wait_for(2, 1'b1, 6);
			end
		join
		check(16'(wake_async), 16'h0000);
		rd(ADDR_BAUD_CTL, 8'h00, 8'h02);
		rd(ADDR_RX_DATA, 8'h00, 8'hff);
		rd(ADDR_FLAGS, 8'h00, 8'h20);
		idle(1);
		sleep <= 1'b0;
		rnd = 8'($urandom);
		node.send_byte(rnd);
		wait_for(2, 1'b1, 40);
		rd(ADDR_RX_DATA, rnd, 8'hff);
		idle(1);
		// at 9/13 rate a 13-bit break reads as a zero byte ending at its stop sample
		wr(ADDR_BAUD_DIV, 8'h0c);
		node.send_zeros(9 * 13);
		wait_for(2, 1'b1, 200);
		rd(ADDR_RX_DATA, 8'h00, 8'hff);
		wr(ADDR_BAUD_DIV, 8'h00);
		idle(1);
		for (int p = 0; p < 2; p++)
		begin
			wr(ADDR_BAUD_CTL, 8'(p) << BC_CLK_POL);
			wr(ADDR_TX_STAT, 8'hb0);
			idle(4);
			check(16'({pins.tx_oe, pins.tx_out}), 16'({1'b1, p[0]}));
			rnd = 8'($urandom);
			wr(ADDR_TX_DATA, rnd);
			idle(20);
			check(16'({pins.rx_oe, pins.rx_out}), 16'({1'b1, rnd[1]}));
			idle(160);
		end
		stop_test();
	end
endmodule
`default_nettype wire
